/* File: lpms_front_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Front end model
// ****************
module lpms_front_model
(
  input  wire logic [15:0] level,
  input  wire logic        alarm_n_o,
  input  wire logic        alarm_n_oe,
  output var  logic        osc_clk,
  output var  logic [15:0] adc_count,
  output var  logic        alarm_pin
);
  initial
  begin
    osc_clk = 1'b0;
    forever #40 osc_clk = ~osc_clk;
  end
  assign adc_count = level;
  // Pull-up on open drain line
  assign alarm_pin = alarm_n_oe ? alarm_n_o : 1'b1;
endmodule : lpms_front_model
`default_nettype wire

/* File: lpms_pkg.sv */
// Overview of operation
// - Device starts in power-down and converts nothing until a mode is written.
// - Result registers read zero after reset until a conversion completes.
// - One-shot command runs one conversion, then returns to power-down itself.
// - One-shot result stays unchanged in the data registers afterwards.
// - Continuous modes convert back to back, overwriting data with each result.
// - Continuous mode runs until power-down is written, then stops converting.
// - Ambient, IR, proximity, each one-shot or continuous, selectable in any order.
// - Integration length is an n-bit count of oscillator ticks, n = 4/8/12/16.
// - Ambient and IR results are unsigned, width equal to the resolution.
// - Proximity conversion drives the LED with programmed current and modulation.
// - Alarm pin is active low open drain: pulls low or releases.
// - Alarm status bit is readable in the first control register.
// - Alarm when the result is above upper or below lower threshold.
// - Alarm fires only after the programmed count of consecutive out-of-window results.
// - Signed proximity scheme compares thresholds as two's complement values.
// - Alarm stays until a transfer to the first control register completes.
// - Mode field: 000 off, 001-011 one-shot, 101-111 continuous, 100 reserved.
package lpms_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [3:0] LPMS_IDX_CTRL1   = 4'h0;
  localparam logic [3:0] LPMS_IDX_CTRL2   = 4'h1;
  localparam logic [3:0] LPMS_IDX_DATA_L  = 4'h2;
  localparam logic [3:0] LPMS_IDX_DATA_H  = 4'h3;
  localparam logic [3:0] LPMS_IDX_LT_L    = 4'h4;
  localparam logic [3:0] LPMS_IDX_LT_H    = 4'h5;
  localparam logic [3:0] LPMS_IDX_HT_L    = 4'h6;
  localparam logic [3:0] LPMS_IDX_HT_H    = 4'h7;
  localparam logic [3:0] LPMS_IDX_TEST    = 4'h8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  LPMS_CTRL_RST   = 8'h00;
  localparam logic [15:0] LPMS_DATA_RST   = 16'h0000;
  localparam logic [15:0] LPMS_LT_RST     = 16'h0000;
  localparam logic [15:0] LPMS_HT_RST     = 16'hFFFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LPMS_OP_LSB      = 5;
  localparam int LPMS_FLAG_BIT    = 2;
  localparam int LPMS_SCHEME_BIT  = 7;
  localparam int LPMS_FREQ_BIT    = 6;
  localparam int LPMS_IS_LSB      = 4;
  localparam int LPMS_RES_LSB     = 2;

  // ****************************************
  // Modes and encodings
  // ****************************************
  localparam logic [2:0] LPMS_OP_OFF      = 3'h0;
  localparam logic [2:0] LPMS_OP_RSVD     = 3'h4;
  localparam logic [1:0] LPMS_Q_PROX      = 2'h3;
  localparam logic [1:0] LPMS_RES_16      = 2'h0;
  localparam logic [1:0] LPMS_RES_12      = 2'h1;
  localparam logic [1:0] LPMS_RES_8       = 2'h2;
  localparam logic [15:0] LPMS_MASK_16    = 16'hFFFF;
  localparam logic [15:0] LPMS_MASK_12    = 16'h0FFF;
  localparam logic [15:0] LPMS_MASK_8     = 16'h00FF;
  localparam logic [15:0] LPMS_MASK_4     = 16'h000F;
  localparam logic [4:0]  LPMS_PERS_1     = 5'h01;
  localparam logic [4:0]  LPMS_PERS_4     = 5'h04;
  localparam logic [4:0]  LPMS_PERS_8     = 5'h08;
  localparam logic [4:0]  LPMS_PERS_16    = 5'h10;

  typedef enum logic [0:0] {
    LPMS_ST_OFF  = 1'b0,
    LPMS_ST_CONV = 1'b1
  } lpms_state_t;

endpackage : lpms_pkg

/* File: lpms_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Port checks
// ****************
module lpms_properties
  import lpms_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc_clk,
  input wire logic [15:0] adc_count,
  input wire logic        led_drive_output,
  input wire logic [1:0]  led_drive_current,
  input wire logic        alarm_n_o,
  input wire logic        alarm_n_oe
);
  logic      wr_q;
  wire logic done = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wr_q <= 1'b0;
    else if (done && pwrite && paddr == 32'h0)
      wr_q <= 1'b1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lat; psel && !penable |-> ##2 pready; endproperty
  a_lat: assert property (p_lat) else $error("late ready");
  property p_map; done |-> pslverr == (paddr[31:6] != 0 || paddr[5:2] > 4'h8); endproperty
  a_map: assert property (p_map) else $error("bad slave error");
  property p_off; !wr_q |-> !led_drive_output && !alarm_n_oe; endproperty
  a_off: assert property (p_off) else $error("active before mode");
  property p_zero; !wr_q && done && !pwrite && paddr[5:3] == 3'h1 |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("data not zero");
  property p_cur; done && pwrite && paddr == 32'h4 |=> led_drive_current == $past(pwdata[5:4]);
  endproperty
  a_cur: assert property (p_cur) else $error("bad drive current");
  property p_od; !alarm_n_o; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_flag; done && !pwrite && paddr == 32'h0 |-> prdata[2] == $past(alarm_n_oe); endproperty
  a_flag: assert property (p_flag) else $error("bad status bit");
  property p_hold; alarm_n_oe && !(done && paddr == 32'h0) |=> alarm_n_oe; endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped");
  property p_clr; $fell(alarm_n_oe) |-> $past(done && paddr == 32'h0); endproperty
  a_clr: assert property (p_clr) else $error("alarm cleared late");
  c_alarm: cover property (alarm_n_oe);
  c_led: cover property (led_drive_output);
  c_err: cover property (pslverr);
endmodule : lpms_properties
`default_nettype wire

/* File: lpms_sequencer.sv */
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module lpms_sequencer
  import lpms_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        osc_clk,
  input  wire logic [15:0] adc_count,
  output var  logic        led_drive_output,
  output var  logic [1:0]  led_drive_current,
  output var  logic        alarm_n_o,
  output var  logic        alarm_n_oe
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic [15:0] adc_s1;
    logic [15:0] adc_s2;
    logic [2:0]  op;
    logic [1:0]  persist;
    logic [7:0]  ctrl2;
    logic [15:0] data;
    logic [15:0] lt;
    logic [15:0] ht;
    logic        flag;
    logic [4:0]  pcnt;
    logic [15:0] icnt;
    lpms_state_t state;
    logic        led_on;
    logic        pin_lo;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lpms_regs_t;

  lpms_regs_t r_q;
  lpms_regs_t r_d;

  // ****************************************
  // Decoders
  // ****************************************
  function automatic logic [15:0] lpms_res_mask(input logic [1:0] res);
    unique case (res)
      LPMS_RES_16: lpms_res_mask = LPMS_MASK_16;
      LPMS_RES_12: lpms_res_mask = LPMS_MASK_12;
      LPMS_RES_8:  lpms_res_mask = LPMS_MASK_8;
      default:     lpms_res_mask = LPMS_MASK_4;
    endcase
  endfunction : lpms_res_mask

  function automatic logic [4:0] lpms_pers(input logic [1:0] p);
    unique case (p)
      2'h0:    lpms_pers = LPMS_PERS_1;
      2'h1:    lpms_pers = LPMS_PERS_4;
      2'h2:    lpms_pers = LPMS_PERS_8;
      default: lpms_pers = LPMS_PERS_16;
    endcase
  endfunction : lpms_pers

  function automatic logic lpms_is_off(input logic [2:0] op);
    lpms_is_off = (op == LPMS_OP_OFF) || (op == LPMS_OP_RSVD);
  endfunction : lpms_is_off

  function automatic logic [15:0] adc_count_masked(input logic [15:0] v, input logic [15:0] m);
    adc_count_masked = v & m;
  endfunction : adc_count_masked

  // ****************************************
  // Next state
  // ****************************************
  logic [15:0] mask;
  logic [15:0] result;
  logic        signed_cmp;
  logic        out_win;
  logic        osc_tick;
  logic        conv_done;
  logic        xfer;
  logic [3:0]  idx;
  logic        mapped;
  logic        ctrl1_done;
  logic [7:0]  rd_byte;

  always_comb
  begin
    r_d        = r_q;
    mask       = lpms_res_mask(r_q.ctrl2[LPMS_RES_LSB +: 2]);
    osc_tick   = r_q.osc_s2 & ~r_q.osc_s3;
    idx        = paddr[5:2];
    mapped     = (paddr[31:6] == 26'h000_0000) && (idx <= LPMS_IDX_TEST);
    xfer       = psel & penable & r_q.pready;
    ctrl1_done = xfer && mapped && (idx == LPMS_IDX_CTRL1);
    result     = adc_count_masked(r_q.adc_s2, mask);
    signed_cmp = (r_q.op[1:0] == LPMS_Q_PROX) && r_q.ctrl2[LPMS_SCHEME_BIT];
    if (signed_cmp && ((result & ~(mask >> 1)) != 16'h0000))
    begin
      result = result | ~(mask >> 1);
    end

    // ****************************************
    // Window compare
    // ****************************************
    // window comparison
    if (signed_cmp)
    begin
      out_win = ($signed(result) > $signed(r_q.ht)) || ($signed(result) < $signed(r_q.lt));
    end
    else
    begin
      out_win = (result > r_q.ht) || (result < r_q.lt);
    end
    conv_done = (r_q.state == LPMS_ST_CONV) && osc_tick && (r_q.icnt == mask);

    // ****************************************
    // Synchronisers
    // ****************************************
    r_d.osc_s1 = osc_clk;
    r_d.osc_s2 = r_q.osc_s1;
    r_d.osc_s3 = r_q.osc_s2;
    r_d.adc_s1 = adc_count;
    r_d.adc_s2 = r_q.adc_s1;

    // ****************************************
    // Integration counter
    // ****************************************
    if ((r_q.state == LPMS_ST_CONV) && osc_tick)
    begin
      r_d.icnt = conv_done ? 16'h0000 : r_q.icnt + 16'h0001;
    end

    // ****************************************
    // Flag clear
    // ****************************************
    // clear flag at end of a first control register transfer
    if (ctrl1_done)
    begin
      r_d.flag = 1'b0;
    end

    // ****************************************
    // Conversion end
    // ****************************************
    if (conv_done)
    begin
      r_d.data = result;
      // restart persistence when back in window
      if (!out_win)
      begin
        r_d.pcnt = 5'h00;
      end
      else if (r_q.pcnt < LPMS_PERS_16)
      begin
        r_d.pcnt = r_q.pcnt + 5'h01;
      end
      // fire after consecutive count, set wins
      if (out_win && ((r_q.pcnt + 5'h01) >= lpms_pers(r_q.persist)))
      begin
        r_d.flag = 1'b1;
      end
      if (!r_q.op[2])
      begin
        r_d.op    = LPMS_OP_OFF;
        r_d.state = LPMS_ST_OFF;
      end
    end

    // ****************************************
    // APB access
    // ****************************************
    r_d.pready  = psel & penable & ~r_q.pready;
    r_d.pslverr = psel & penable & ~r_q.pready & ~mapped;
    unique case (idx)
      LPMS_IDX_CTRL1:  rd_byte = {r_q.op, 2'b00, r_q.flag, r_q.persist};
      LPMS_IDX_CTRL2:  rd_byte = r_q.ctrl2;
      LPMS_IDX_DATA_L: rd_byte = r_q.data[7:0];
      LPMS_IDX_DATA_H: rd_byte = r_q.data[15:8];
      LPMS_IDX_LT_L:   rd_byte = r_q.lt[7:0];
      LPMS_IDX_LT_H:   rd_byte = r_q.lt[15:8];
      LPMS_IDX_HT_L:   rd_byte = r_q.ht[7:0];
      LPMS_IDX_HT_H:   rd_byte = r_q.ht[15:8];
      default:         rd_byte = 8'h00;
    endcase
    // flag readable in first control register
    if (psel & penable & ~r_q.pready & ~pwrite)
    begin
      r_d.prdata = mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (xfer && pwrite && mapped)
    begin
      unique case (idx)
        LPMS_IDX_CTRL1:
        begin
          r_d.op      = pwdata[LPMS_OP_LSB +: 3];
          r_d.persist = pwdata[1:0];
          r_d.icnt    = 16'h0000;
          r_d.pcnt    = 5'h00;
          // any mode may follow any other
          r_d.state   = lpms_is_off(pwdata[LPMS_OP_LSB +: 3]) ? LPMS_ST_OFF : LPMS_ST_CONV;
        end
        LPMS_IDX_CTRL2:  r_d.ctrl2      = pwdata[7:0];
        LPMS_IDX_LT_L:   r_d.lt[7:0]    = pwdata[7:0];
        LPMS_IDX_LT_H:   r_d.lt[15:8]   = pwdata[7:0];
        LPMS_IDX_HT_L:   r_d.ht[7:0]    = pwdata[7:0];
        LPMS_IDX_HT_H:   r_d.ht[15:8]   = pwdata[7:0];
        default:         r_d.ht         = r_q.ht;
      endcase
    end

    // ****************************************
    // LED drive
    // ****************************************
    // LED drive during proximity conversion
    if ((r_d.state == LPMS_ST_CONV) && (r_d.op[1:0] == LPMS_Q_PROX))
    begin
      if (!r_q.ctrl2[LPMS_FREQ_BIT])
      begin
        r_d.led_on = 1'b1;
      end
      else if (osc_tick)
      begin
        r_d.led_on = ~r_q.led_on;
      end
    end
    else
    begin
      r_d.led_on = 1'b0;
    end
    r_d.pin_lo = 1'b0;
  end

  // ****************************************
  // Registers
  // ****************************************
  // reset to power-down, data zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q.osc_s1  <= 1'b0;
      r_q.osc_s2  <= 1'b0;
      r_q.osc_s3  <= 1'b0;
      r_q.adc_s1  <= '0;
      r_q.adc_s2  <= '0;
      r_q.op      <= LPMS_CTRL_RST[LPMS_OP_LSB +: 3];
      r_q.persist <= '0;
      r_q.ctrl2   <= LPMS_CTRL_RST;
      r_q.data    <= LPMS_DATA_RST;
      r_q.lt      <= LPMS_LT_RST;
      r_q.ht      <= LPMS_HT_RST;
      r_q.flag    <= LPMS_CTRL_RST[LPMS_FLAG_BIT];
      r_q.pcnt    <= '0;
      r_q.icnt    <= '0;
      r_q.state   <= LPMS_ST_OFF;
      r_q.led_on  <= 1'b0;
      r_q.pin_lo  <= 1'b0;
      r_q.prdata  <= '0;
      r_q.pready  <= 1'b0;
      r_q.pslverr <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata            = r_q.prdata;
  assign pready            = r_q.pready;
  assign pslverr           = r_q.pslverr;
  assign led_drive_output  = r_q.led_on;
  assign led_drive_current = r_q.ctrl2[LPMS_IS_LSB +: 2];
  assign alarm_n_o         = r_q.pin_lo;
  assign alarm_n_oe        = r_q.flag;

endmodule : lpms_sequencer
`default_nettype wire

/* File: test_light_proximity_measure_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Sequencer bench
// ****************
module test_light_proximity_measure_sequencer
  import lpms_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_clk, err;
  logic        led_drive_output, alarm_n_o, alarm_n_oe, alarm_pin;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] level, adc_count;
  logic [1:0]  led_drive_current;
  logic [7:0]  rd;
  logic        led_q;
  logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  int          num_errors = 0;
  int          num_checks = 0;
  lpms_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_clk(osc_clk), .adc_count(adc_count),
    .led_drive_output(led_drive_output), .led_drive_current(led_drive_current),
    .alarm_n_o(alarm_n_o), .alarm_n_oe(alarm_n_oe));
  lpms_front_model u_front (.level(level), .alarm_n_o(alarm_n_o), .alarm_n_oe(alarm_n_oe),
    .osc_clk(osc_clk), .adc_count(adc_count), .alarm_pin(alarm_pin));
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {26'h0, idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle;
    do
      xfer(1'b0, LPMS_IDX_CTRL1, 8'h00);
    while (rd[7:5] !== LPMS_OP_OFF);
  endtask : idle
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    conclude();
  end
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = 32'h0;
    pwdata = 32'h0;
    level  = 16'h1234;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b0, 4'(i), 8'h00);
      chk(rd, rv[i]);
    end
    xfer(1'b0, 4'hF, 8'h00);
    chk({7'h0, err}, 8'h01);
    xfer(1'b1, LPMS_IDX_CTRL2, 8'h3C);
    for (int op = 1; op < 4; op++)
    begin
      level <= 16'h1230 + 16'(op);
      xfer(1'b1, LPMS_IDX_CTRL1, 8'(op << 5));
      @(posedge pclk);
      chk({6'h0, led_drive_current}, 8'h03);
      chk({7'h0, led_drive_output}, 8'(op == 3));
      idle();
      xfer(1'b0, LPMS_IDX_DATA_L, 8'h00);
      chk(rd, 8'(op));
    end
    level <= 16'h000A;
    repeat (300) @(posedge pclk);
    xfer(1'b0, LPMS_IDX_DATA_L, 8'h00);
    chk(rd, 8'h03);
    xfer(1'b1, LPMS_IDX_CTRL2, 8'h08);
    level <= 16'h1234;
    xfer(1'b1, LPMS_IDX_CTRL1, 8'h20);
    idle();
    xfer(1'b0, LPMS_IDX_DATA_L, 8'h00);
    chk(rd, 8'h34);
    xfer(1'b0, LPMS_IDX_DATA_H, 8'h00);
    chk(rd, 8'h00);
    xfer(1'b1, LPMS_IDX_CTRL2, 8'h7C);
    xfer(1'b1, LPMS_IDX_CTRL1, 8'h60);
    led_q = led_drive_output;
    repeat (8) @(posedge pclk);
    chk({7'h0, led_drive_output ^ led_q}, 8'h01);
    idle();
    chk({7'h0, led_drive_output}, 8'h00);
    xfer(1'b1, LPMS_IDX_CTRL2, 8'h0C);
    xfer(1'b1, LPMS_IDX_CTRL1, 8'hA0);
    for (int k = 5; k < 8; k++)
    begin
      level <= 16'(k);
      repeat (300) @(posedge pclk);
      if (k == 6)
        xfer(1'b1, LPMS_IDX_CTRL1, 8'h00);
      xfer(1'b0, LPMS_IDX_DATA_L, 8'h00);
      chk(rd, 8'(k == 7 ? 6 : k));
    end
    xfer(1'b1, LPMS_IDX_HT_L, 8'h05);
    xfer(1'b1, LPMS_IDX_HT_H, 8'h00);
    xfer(1'b1, LPMS_IDX_LT_L, 8'h02);
    level <= 16'h0009;
    xfer(1'b1, LPMS_IDX_CTRL1, 8'hA1);
    repeat (300) @(posedge pclk);
    chk({7'h0, alarm_pin}, 8'h01);
    repeat (400) @(posedge pclk);
    chk({7'h0, alarm_pin}, 8'h00);
    xfer(1'b0, LPMS_IDX_CTRL1, 8'h00);
    chk(rd, 8'hA5);
    chk({7'h0, alarm_n_oe}, 8'h00);
    xfer(1'b1, LPMS_IDX_CTRL1, 8'h00);
    xfer(1'b1, LPMS_IDX_CTRL2, 8'hB4);
    xfer(1'b1, LPMS_IDX_HT_L, 8'hFF);
    xfer(1'b1, LPMS_IDX_HT_H, 8'h05);
    xfer(1'b1, LPMS_IDX_LT_L, 8'h00);
    xfer(1'b1, LPMS_IDX_LT_H, 8'hF8);
    level <= 16'h0F00;
    xfer(1'b1, LPMS_IDX_CTRL1, 8'h60);
    idle();
    chk(rd, 8'h00);
    xfer(1'b0, LPMS_IDX_DATA_L, 8'h00);
    chk(rd, 8'h00);
    xfer(1'b0, LPMS_IDX_DATA_H, 8'h00);
    chk(rd, 8'hFF);
    conclude();
  end
endmodule : test_light_proximity_measure_sequencer
bind lpms_sequencer lpms_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk), .adc_count(adc_count),
  .led_drive_output(led_drive_output), .led_drive_current(led_drive_current),
  .alarm_n_o(alarm_n_o), .alarm_n_oe(alarm_n_oe));
`default_nettype wire
